// ==== hw/rsf_pkg.sv ====
/*
 Package of the real-time clock status flags block: register offsets, status word layout,
 reset values and timing constants shared by the design files.
 Assumes a single 50 MHz clock and a plain address/strobe register port.
*/
package rsf_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets on the plain register port.
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h1;
   localparam logic [3:0] OFS_IRQ_EN = 4'h2;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h3;
   localparam logic [3:0] OFS_SIM_CTRL = 4'h4;

   // Status word bit positions.
   localparam int BIT_ALARM_EVT = 5;
   localparam int BIT_TSTAMP_EVT = 3;
   localparam int BIT_TIME_UNSAFE = 2;
   localparam int BIT_ALARM_UNSAFE = 1;
   localparam int BIT_HALF_SEC = 0;

   // Interrupt status layout.
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_TSTAMP = 1;
   localparam int IRQ_HALF = 2;
   localparam int IRQ_W = 3;

   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [2:0] IRQ_EN_RST = 3'h0;

   // Second timing.
   localparam longint CLK_HZ = 50000000;
   localparam longint SECOND_NS = 1000000000;
   localparam longint CLK_NS = SECOND_NS / CLK_HZ;
   localparam int HALF_SEC_CYC = int'((SECOND_NS / 2) / CLK_NS);
   // Window around a second rollover in which the time counters may change.
   localparam int UNSAFE_NS = 1000;
   localparam int UNSAFE_CYC = int'(UNSAFE_NS / CLK_NS);

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } rsf_req_t;

   typedef struct packed {
      logic alarm;
      logic tstamp;
   } rsf_evt_t;

endpackage : rsf_pkg

// ==== hw/rsf_half_sec.sv ====
/*
 Half-second timebase: counts clock cycles and reports which half of the second runs,
 plus windows near each half-second boundary in which counters may change.
 Assumes a free running clock at the rate given in the package.
*/
module rsf_half_sec #(
   parameter int HALF_CYC = rsf_pkg::HALF_SEC_CYC,
   parameter int GUARD_CYC = rsf_pkg::UNSAFE_CYC
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   output logic half_r, // High in the second half of a second.
   output logic near_edge_r, // High close to a half-second boundary.
   output logic half_tick_r // One-cycle pulse at each half-second boundary.
);

   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic half_nxt;
   logic near_nxt;
   logic tick_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r + 32'h1;
      half_nxt = half_r;
      tick_nxt = 1'b0;
      if (cnt_r == 32'(HALF_CYC - 1))
      begin
         cnt_nxt = 32'h0;
         half_nxt = ~half_r;
         tick_nxt = 1'b1;
      end
      // Guard both sides of the boundary so a read never straddles a carry.
      near_nxt = (cnt_nxt < 32'(GUARD_CYC)) || (cnt_nxt >= 32'(HALF_CYC - GUARD_CYC));
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= 32'h0;
         half_r <= 1'b0;
         near_edge_r <= 1'b1;
         half_tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         half_r <= half_nxt;
         near_edge_r <= near_nxt;
         half_tick_r <= tick_nxt;
      end
   end

endmodule : rsf_half_sec

// ==== hw/rsf_irq.sv ====
/*
 Interrupt gathering: sticky status bits, an enable mask and a write-one-to-clear register,
 driving one level interrupt output.
 Assumes single-cycle event pulses and single-cycle write strobes.
*/
module rsf_irq #(
   parameter int W = rsf_pkg::IRQ_W
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [W-1:0] evt, // Event pulses.
   input wire logic en_we, // Write strobe for the enable register.
   input wire logic clr_we, // Write strobe for the clear register.
   input wire logic [W-1:0] wdata, // Write data.
   output logic [W-1:0] stat_r, // Sticky status.
   output logic [W-1:0] en_r, // Enable mask.
   output logic irq_r // Level interrupt.
);

   logic [W-1:0] stat_nxt;
   logic [W-1:0] en_nxt;
   logic irq_nxt;

   always_comb
   begin
      // An event in the clearing cycle survives the clear.
      stat_nxt = (stat_r & ~(clr_we ? wdata : '0)) | evt;
      en_nxt = en_we ? wdata : en_r;
      irq_nxt = |(stat_nxt & en_nxt);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stat_r <= '0;
         en_r <= rsf_pkg::IRQ_EN_RST;
         irq_r <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         en_r <= en_nxt;
         irq_r <= irq_nxt;
      end
   end

endmodule : rsf_irq

// ==== hw/rsf_top.sv ====
/*
 Status word of a real-time clock unit: alarm and timestamp event flags, time-read and
 alarm-update safety flags, half-second phase, plus interrupt gathering.
 Assumes event pulses from the alarm matcher and timestamp capture, one cycle each,
 synchronous to clk, and a plain address/strobe register port.
*/
// Behaviour
// - Alarm event sets sticky flag at status bit 5; zero until an alarm.
// - Timestamp event sets sticky flag at status bit 3; zero until an event.
// - Bit 2 high while time counters may change under a read.
// - Bit 1 high while alarm time, date, mask, enable or repeat may change.
// - Bit 0 is one in the second half of each second, else zero.
// - Status bits 15 to 6 and bit 4 read as zero.
module rsf_top #(
   parameter int HALF_CYC = rsf_pkg::HALF_SEC_CYC,
   parameter int GUARD_CYC = rsf_pkg::UNSAFE_CYC
) (
   input wire logic clk, // System clock, 50 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [rsf_pkg::ADDR_W-1:0] addr, // Register address.
   input wire logic [rsf_pkg::DATA_W-1:0] wdata, // Write data.
   input wire logic wr, // Write strobe.
   input wire logic rd, // Read strobe.
   input wire logic alarm_evt, // Alarm match pulse.
   input wire logic tstamp_evt, // Timestamp capture pulse.
   input wire logic alarm_busy, // Alarm logic updating its registers.
   output logic [rsf_pkg::DATA_W-1:0] rdata_r, // Read data, cycle after rd.
   output logic irq_r // Level interrupt.
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_UNSAFE = 3'b010,
      ST_HOLD = 3'b100
   } rsf_sync_st_t;

   rsf_pkg::rsf_req_t req;
   rsf_pkg::rsf_evt_t evt;
   rsf_sync_st_t st_r;
   rsf_sync_st_t st_nxt;
   logic half_w;
   logic near_w;
   logic tick_w;
   logic alarm_flag_r;
   logic alarm_flag_nxt;
   logic ts_flag_r;
   logic ts_flag_nxt;
   logic time_unsafe_r;
   logic time_unsafe_nxt;
   logic alarm_unsafe_r;
   logic alarm_unsafe_nxt;
   logic [rsf_pkg::DATA_W-1:0] rdata_nxt;
   logic [rsf_pkg::DATA_W-1:0] status_w;
   logic status_we;
   logic irq_en_we;
   logic irq_clr_we;
   logic alarm_clr;
   logic ts_clr;
   logic [rsf_pkg::IRQ_W-1:0] irq_stat;
   logic [rsf_pkg::IRQ_W-1:0] irq_en;
   logic irq_w;
   logic irq_nxt;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign evt = '{alarm: alarm_evt, tstamp: tstamp_evt};

   rsf_half_sec #(
      .HALF_CYC(HALF_CYC),
      .GUARD_CYC(GUARD_CYC)
   ) u_half (
      .clk(clk),
      .rst_n(rst_n),
      .half_r(half_w),
      .near_edge_r(near_w),
      .half_tick_r(tick_w)
   );

   rsf_irq #(
      .W(rsf_pkg::IRQ_W)
   ) u_irq (
      .clk(clk),
      .rst_n(rst_n),
      .evt({tick_w, evt.tstamp, evt.alarm}),
      .en_we(irq_en_we),
      .clr_we(irq_clr_we),
      .wdata(req.wdata[rsf_pkg::IRQ_W-1:0]),
      .stat_r(irq_stat),
      .en_r(irq_en),
      .irq_r(irq_w)
   );

   // Write decode. Unmapped offsets and the read-only interrupt status take no write.
   always_comb
   begin
      status_we = 1'b0;
      irq_en_we = 1'b0;
      irq_clr_we = 1'b0;
      if (req.wr)
      begin
         status_we = hit(req.addr, rsf_pkg::OFS_STATUS);
         irq_en_we = hit(req.addr, rsf_pkg::OFS_IRQ_EN);
         irq_clr_we = hit(req.addr, rsf_pkg::OFS_IRQ_CLR);
      end
   end

   // A zero written to an event flag clears it; the read-only bits have no clear.
   always_comb
   begin
      alarm_clr = 1'b0;
      ts_clr = 1'b0;
      if (status_we)
      begin
         alarm_clr = !req.wdata[rsf_pkg::BIT_ALARM_EVT];
         ts_clr = !req.wdata[rsf_pkg::BIT_TSTAMP_EVT];
      end
   end

   // Event flags: a zero written clears, a one is ignored, and a new event wins.
   always_comb
   begin
      alarm_flag_nxt = alarm_flag_r;
      ts_flag_nxt = ts_flag_r;
      if (alarm_clr)
      begin
         alarm_flag_nxt = 1'b0;
      end
      if (ts_clr)
      begin
         ts_flag_nxt = 1'b0;
      end
      if (evt.alarm)
      begin
         alarm_flag_nxt = 1'b1;
      end
      if (evt.tstamp)
      begin
         ts_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         alarm_flag_r <= 1'b0;
         ts_flag_r <= 1'b0;
      end
      else
      begin
         alarm_flag_r <= alarm_flag_nxt;
         ts_flag_r <= ts_flag_nxt;
      end
   end

   // Alarm update tracker: the flag is high while the alarm logic reports activity and in
   // every guard window, with or without activity, since matching runs on the second boundary.
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:
         begin
            if (alarm_busy)
            begin
               st_nxt = ST_UNSAFE;
            end
            else if (near_w)
            begin
               st_nxt = ST_HOLD;
            end
         end
         ST_UNSAFE:
         begin
            if (!alarm_busy)
            begin
               st_nxt = near_w ? ST_HOLD : ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            if (alarm_busy)
            begin
               st_nxt = ST_UNSAFE;
            end
            else if (!near_w)
            begin
               st_nxt = ST_IDLE;
            end
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
      alarm_unsafe_nxt = (st_nxt != ST_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= ST_HOLD;
         alarm_unsafe_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         alarm_unsafe_r <= alarm_unsafe_nxt;
      end
   end

   // Time-read safety flag: follows the guard window around each half-second carry.
   always_comb
   begin
      time_unsafe_nxt = near_w;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         time_unsafe_r <= 1'b1;
      end
      else
      begin
         time_unsafe_r <= time_unsafe_nxt;
      end
   end

   // Unused positions stay zero.
   always_comb
   begin
      status_w = rsf_pkg::STATUS_RST;
      status_w[rsf_pkg::BIT_ALARM_EVT] = alarm_flag_r;
      status_w[rsf_pkg::BIT_TSTAMP_EVT] = ts_flag_r;
      status_w[rsf_pkg::BIT_TIME_UNSAFE] = time_unsafe_r;
      status_w[rsf_pkg::BIT_ALARM_UNSAFE] = alarm_unsafe_r;
      status_w[rsf_pkg::BIT_HALF_SEC] = half_w;
   end

   // Read port: data stands only in the cycle after the read strobe.
   always_comb
   begin
      rdata_nxt = '0;
      if (req.rd)
      begin
         case (req.addr)
            rsf_pkg::OFS_STATUS:
            begin
               rdata_nxt = status_w;
            end
            rsf_pkg::OFS_IRQ_STAT:
            begin
               rdata_nxt = {13'h0, irq_stat};
            end
            rsf_pkg::OFS_IRQ_EN:
            begin
               rdata_nxt = {13'h0, irq_en};
            end
            default:
            begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // The interrupt pin leaves through its own flop so that it comes straight from a
   // register; this costs one cycle after the gathered status bit sets.
   always_comb
   begin
      irq_nxt = irq_w;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

endmodule : rsf_top

// ==== sim/rsf_asserts.sv ====
/*
 Checker of the status flags block, watching only the ports of rsf_top.
 Assumes one clock and a synchronous active-low reset.
*/
module rsf_asserts (
   input wire logic clk, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic [rsf_pkg::ADDR_W-1:0] addr, // Address.
   input wire logic [rsf_pkg::DATA_W-1:0] wdata, // Write data.
   input wire logic wr, // Write strobe.
   input wire logic rd, // Read strobe.
   input wire logic alarm_evt, // Alarm pulse.
   input wire logic tstamp_evt, // Timestamp pulse.
   input wire logic alarm_busy, // Alarm update busy.
   input wire logic [rsf_pkg::DATA_W-1:0] rdata_r, // Read data.
   input wire logic irq_r // Interrupt.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_st;
      rd && addr == rsf_pkg::OFS_STATUS;
   endsequence
   sequence s_two_rd;
      s_rd_st ##2 s_rd_st ##1 1'b1;
   endsequence
   property p_alarm_set;
      alarm_evt ##1 !wr ##1 s_rd_st |=> rdata_r[5];
   endproperty
   property p_ts_set;
      tstamp_evt ##1 !wr ##1 s_rd_st |=> rdata_r[3];
   endproperty
   property p_clear;
      (wr && addr == rsf_pkg::OFS_STATUS && !wdata[5] && !wdata[3] && !alarm_evt && !tstamp_evt)
      ##1 (!alarm_evt && !tstamp_evt && !wr) ##1 s_rd_st |=> !rdata_r[5] && !rdata_r[3];
   endproperty
   property p_busy;
      alarm_busy ##1 (alarm_busy && rd && addr == rsf_pkg::OFS_STATUS) |=> rdata_r[1];
   endproperty
   property p_zero;
      s_rd_st |=> rdata_r[15:6] == 10'h000 && !rdata_r[4];
   endproperty
   property p_unsafe;
      s_two_rd ##0 (rdata_r[0] != $past(rdata_r[0], 2)) |-> rdata_r[2];
   endproperty
   property p_half;
      s_two_rd ##0 (!rdata_r[2] && !$past(rdata_r[2], 2)) |-> rdata_r[0] == $past(rdata_r[0], 2);
   endproperty
   property p_idle;
      !rd || addr > 4'h3 |=> rdata_r == 16'h0000;
   endproperty
   property p_irq_off;
      wr && addr == rsf_pkg::OFS_IRQ_EN && wdata[2:0] == 3'h0 |-> ##2 !irq_r;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");
   a_ts_set: assert property (p_ts_set) else $error("timestamp flag not set");
   a_clear: assert property (p_clear) else $error("event flag not cleared");
   a_busy: assert property (p_busy) else $error("alarm unsafe low while busy");
   a_zero: assert property (p_zero) else $error("unused status bit set");
   a_unsafe: assert property (p_unsafe) else $error("half flip while safe");
   a_half: assert property (p_half) else $error("half bit moved in safe span");
   a_idle: assert property (p_idle) else $error("read data not zero");
   a_irq_off: assert property (p_irq_off) else $error("interrupt high with all sources masked");
endmodule : rsf_asserts

bind rsf_top rsf_asserts chk_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .alarm_evt(alarm_evt), .tstamp_evt(tstamp_evt),
   .alarm_busy(alarm_busy), .rdata_r(rdata_r), .irq_r(irq_r));

// ==== sim/rsf_tb_top.sv ====
/*
 Self-checking bench of the status flags block.
 Assumes the short half-second count below keeps the run brief.
*/
module rsf_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic alarm_evt = 1'b0;
   logic tstamp_evt = 1'b0;
   logic alarm_busy = 1'b0;
   logic [15:0] rdata_r;
   logic irq_r;
   logic [15:0] d;
   logic [15:0] prev;
   int n_fail = 0;
   int num_checks = 0;
   int last = -1;
   int n_tog = 0;
   int safe = 0;
   always #10 clk = ~clk;
   rsf_top #(.HALF_CYC(64), .GUARD_CYC(4)) dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .alarm_evt(alarm_evt), .tstamp_evt(tstamp_evt),
      .alarm_busy(alarm_busy), .rdata_r(rdata_r), .irq_r(irq_r));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata_r;
   endtask : rd_reg
   task automatic pulse(input logic a, input logic t);
      @(posedge clk);
      alarm_evt <= a;
      tstamp_evt <= t;
      @(posedge clk);
      alarm_evt <= 1'b0;
      tstamp_evt <= 1'b0;
   endtask : pulse
   task automatic rd_st(input logic [15:0] exp);
      rd_reg(rsf_pkg::OFS_STATUS);
      check(d & 16'hfff8, exp);
   endtask : rd_st
   task automatic irq_is(input logic v);
      repeat (2) @(posedge clk);
      #1;
      check(16'(irq_r), 16'(v));
   endtask : irq_is
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_st(16'h0000);
      check(d & 16'h0001, 16'h0000);
      pulse(1'b1, 1'b0);
      rd_st(16'h0020);
      pulse(1'b0, 1'b1);
      rd_st(16'h0028);
      wr_reg(rsf_pkg::OFS_STATUS, 16'hffff);
      rd_st(16'h0028);
      wr_reg(rsf_pkg::OFS_STATUS, 16'h0020);
      rd_st(16'h0020);
      wr_reg(rsf_pkg::OFS_STATUS, 16'h0000);
      rd_st(16'h0000);
      @(posedge clk);
      alarm_busy <= 1'b1;
      rd_reg(rsf_pkg::OFS_STATUS);
      check(16'(d[1]), 16'h0001);
      @(posedge clk);
      alarm_busy <= 1'b0;
      // Reads come every two cycles, so one half second spans 32 reads.
      for (int i = 0; i < 100; i++)
      begin
         prev = d;
         rd_reg(rsf_pkg::OFS_STATUS);
         if (d[2:1] === 2'b00)
            safe = 1;
         if (i > 0 && d[0] !== prev[0])
         begin
            check(16'(d[2]), 16'h0001);
            if (last >= 0)
               check(16'(i - last), 16'h0020);
            last = i;
            n_tog++;
         end
      end
      check(16'(n_tog >= 2), 16'h0001);
      check(16'(safe), 16'h0001);
      wr_reg(rsf_pkg::OFS_IRQ_CLR, 16'h0007);
      wr_reg(rsf_pkg::OFS_IRQ_EN, 16'h0001);
      rd_reg(rsf_pkg::OFS_IRQ_EN);
      check(d, 16'h0001);
      irq_is(1'b0);
      pulse(1'b1, 1'b0);
      irq_is(1'b1);
      rd_reg(rsf_pkg::OFS_IRQ_STAT);
      check(d & 16'h0003, 16'h0001);
      wr_reg(rsf_pkg::OFS_IRQ_CLR, 16'h0001);
      irq_is(1'b0);
      wr_reg(rsf_pkg::OFS_IRQ_EN, 16'h0000);
      pulse(1'b1, 1'b0);
      irq_is(1'b0);
      wr_reg(4'h9, 16'hffff);
      rd_reg(4'h9);
      check(d, 16'h0000);
      rd_reg(rsf_pkg::OFS_SIM_CTRL);
      check(d, 16'h0000);
      finish_test();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      finish_test();
   end
endmodule : rsf_tb_top
